// ### inc/cid_params.svh
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH

// =====================================================================
// Register map
`define CID_ENTRY_OFFSET      10'h004

// =====================================================================
// Entry field positions (vector index, bit 31 is the leftmost field)
`define CID_F_PRIMARY         31
`define CID_F_EXT_HI          30
`define CID_F_EXT_LO          20
`define CID_F_EXT_WILD_HI     25
`define CID_F_PRIV            19
`define CID_F_SRC1            18
`define CID_F_SRC2            17
`define CID_F_WBACK           16
`define CID_F_CR_EN           15
`define CID_F_CR_HI           13
`define CID_F_CR_LO           11
`define CID_F_REGNUM_HI       9
`define CID_F_REGNUM_LO       6
`define CID_F_TYPE_HI         5
`define CID_F_TYPE_LO         4
`define CID_F_WILDCARD        1
`define CID_F_ENABLE          0

// Bits that hold storage; reserved bits 14, 10, 3 and 2 read as zero unless ENTRY_INIT sets them
`define CID_ENTRY_MASK        32'hFFFF_BBF3

// =====================================================================
// Opcode values and entry reset word
`define CID_PRIMARY_OP0       6'h00
`define CID_PRIMARY_OP4       6'h04
`define CID_ENTRY_RESET       32'h0000_0000

`endif

// ### inc/cid_pkg.sv
package cid_pkg;

    typedef enum logic [1:0] {
        CID_EARLY_CONFIRM = 2'h0,
        CID_LATE_CONFIRM  = 2'h1,
        CID_AUTONOMOUS    = 2'h2,
        CID_SET_POINTER   = 2'h3
    } cid_exec_t;

endpackage : cid_pkg

// ### src/cid_decode.sv
`timescale 1ns/100ps
`include "cid_params.svh"

// Overview of operation
// - Every entry is loaded at reset from its own init attribute.
// - Bit 0 picks primary opcode 0 or 4; bits 1:11 hold extended opcode.
// - Entry bit 12 set: instruction allowed only in privileged mode.
// - Entry bit 13 set: read first source operand from register file.
// - Entry bit 14 set: read second source operand from register file.
// - Entry bit 15 set: write result into target register.
// - Entry bit 16 set: return condition bits to field named by bits 18:20.
// - Condition field selector has no effect while condition return is off.
// - Bits 26:27 give type: early, late, autonomous, or set pointer.
// - Register number only sets pointer when type is 11; still readable.
// - Wildcard bit 30 set: compare extended bits 6:11 only, else all.
// - Only entries with bit 31 set take part in decode.

module cid_decode #(
    parameter int                      NUM_ENTRIES = 16,
    parameter logic [NUM_ENTRIES-1:0][31:0] ENTRY_INIT = '0
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Control register bus slave
    input  wire logic                  reg_en,
    input  wire logic                  reg_wr,
    input  wire logic [9:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    output logic      [31:0]           reg_rdata,
    output logic                       reg_ack,
    // Instruction from the pipeline
    input  wire logic                  instr_valid,
    input  wire logic [31:0]           instr,
    input  wire logic                  priv_mode,
    // Decode result, one cycle after instr_valid, and the entry pointer
    output logic                       dec_valid,
    output logic                       dec_hit,
    output logic [3:0]                 dec_entry,
    output logic                       dec_permitted,
    output logic                       dec_priv_fault,
    output logic                       privileged_only,
    output logic                       first_source_read_enable,
    output logic                       second_source_read_enable,
    output logic                       result_writeback_enable,
    output logic                       condition_return_enable,
    output logic [2:0]                 condition_target_select,
    output cid_pkg::cid_exec_t         dec_exec_type,
    output logic [3:0]                 entry_pointer
);
    import cid_pkg::*;

    // =================================================================
    // Parameter check
    // Pointer and entry index are four bits wide; a larger table
    // would need wider ports, and any size other than 16 is refused while elaborating
    if (NUM_ENTRIES != 16) begin : g_bad_entries
        $error("cid_decode: the 4-bit pointer serves exactly 16 entries");
    end

    // =================================================================
    // State
    // Whole module state; one process computes the next copy, one registers it
    typedef struct packed {
        logic [NUM_ENTRIES-1:0][31:0] entry;
        logic [3:0]                   ptr;
        logic [31:0]                  rdata;
        logic                         ack;
        logic                         valid;
        logic                         hit;
        logic [3:0]                   idx;
        logic                         permitted;
        logic                         fault;
        logic                         priv;
        logic                         src1;
        logic                         src2;
        logic                         wback;
        logic                         cr_en;
        logic [2:0]                   cr_sel;
        cid_exec_t                    etype;
    } cid_state_t;

    cid_state_t state;
    cid_state_t next_state;

    // =================================================================
    // Entry fields
    // Type field, read both when a write arrives and when an entry matches
    function automatic cid_exec_t cid_type_of(input logic [31:0] e);
        return cid_exec_t'(e[`CID_F_TYPE_HI:`CID_F_TYPE_LO]);
    endfunction : cid_type_of

    // Privileged-only entries are refused outside privileged mode
    function automatic logic cid_priv_ok(input logic [31:0] e, input logic p);
        return !e[`CID_F_PRIV] || p;
    endfunction : cid_priv_ok

    // =================================================================
    // Entry match
    // A disabled entry never matches, whatever its opcode fields hold
    function automatic logic cid_match(input logic [31:0] e, input logic [31:0] ins);
        logic [5:0]  prim;
        logic        ext_ok;
        // Both primary opcodes share one select bit
        prim = e[`CID_F_PRIMARY] ? `CID_PRIMARY_OP4 : `CID_PRIMARY_OP0;
        // Wildcard leaves the primary opcode and only the low six extended opcode bits in the compare
        if (e[`CID_F_WILDCARD]) begin
            ext_ok = (e[`CID_F_EXT_WILD_HI:`CID_F_EXT_LO] == ins[5:0]);
        end else begin
            ext_ok = (e[`CID_F_EXT_HI:`CID_F_EXT_LO] == ins[10:0]);
        end
        return e[`CID_F_ENABLE] && (ins[31:26] == prim) && ext_ok;
    endfunction : cid_match

    // =================================================================
    // Entry select
    logic [31:0] sel_entry;
    logic        sel_hit;
    logic [3:0]  sel_idx;

    // Lowest index wins when software leaves two entries overlapping
    always_comb begin
        sel_entry = 32'h0000_0000;
        sel_hit   = 1'b0;
        sel_idx   = 4'h0;
        // Counting down lets the lowest matching index overwrite the others
        for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
            if (cid_match(state.entry[i], instr)) begin
                sel_entry = state.entry[i];
                sel_hit   = 1'b1;
                sel_idx   = 4'(i);
            end
        end
    end

    // =================================================================
    // Next state
    logic        bus_hit;
    logic [31:0] wmask;

    always_comb begin
        next_state = state;
        bus_hit    = reg_en && (reg_addr == `CID_ENTRY_OFFSET);
        wmask      = reg_wdata & `CID_ENTRY_MASK;

        // Bus slave: ack one cycle after a request at our offset only.
        // A request still held in the ack cycle is not taken a second time.
        next_state.ack = bus_hit && !state.ack;
        if (bus_hit && !state.ack) begin
            if (reg_wr) begin
                // The pointer never steps by itself: software reloads it per entry
                if (cid_type_of(reg_wdata) == CID_SET_POINTER) begin
                    next_state.ptr = reg_wdata[`CID_F_REGNUM_HI:`CID_F_REGNUM_LO];
                end else begin
                    // Reserved bits are dropped so a written entry never reads back stray ones
                    next_state.entry[state.ptr] = wmask;
                end
                next_state.rdata = 32'h0000_0000;
            end else begin
                next_state.rdata = state.entry[state.ptr];
            end
        end

        // Decode: outputs other than dec_valid only meaningful with a hit; zero otherwise
        next_state.valid     = instr_valid;
        next_state.hit       = instr_valid && sel_hit;
        next_state.idx       = sel_idx;
        next_state.priv      = sel_entry[`CID_F_PRIV];
        // Fault and permit both go out so the pipeline needs no decode of its own;
        // privileged mode is the one sampled with the instruction
        next_state.fault     = instr_valid && sel_hit
                               && !cid_priv_ok(sel_entry, priv_mode);
        next_state.permitted = instr_valid && sel_hit
                               && cid_priv_ok(sel_entry, priv_mode);
        next_state.src1      = sel_entry[`CID_F_SRC1];
        next_state.src2      = sel_entry[`CID_F_SRC2];
        next_state.wback     = sel_entry[`CID_F_WBACK];
        next_state.cr_en     = sel_entry[`CID_F_CR_EN];
        next_state.cr_sel    = sel_entry[`CID_F_CR_EN] ?
                               sel_entry[`CID_F_CR_HI:`CID_F_CR_LO] : 3'h0;
        next_state.etype     = cid_type_of(sel_entry);
        // Options are forced to zero on a miss so a stale entry never leaks out
        if (!(instr_valid && sel_hit)) begin
            next_state.priv   = 1'b0;
            next_state.src1   = 1'b0;
            next_state.src2   = 1'b0;
            next_state.wback  = 1'b0;
            next_state.cr_en  = 1'b0;
            next_state.cr_sel = 3'h0;
            next_state.etype  = CID_EARLY_CONFIRM;
            next_state.idx    = 4'h0;
        end
    end

    // =================================================================
    // State register
    // Reset reloads every entry from its init attribute; no software step needed
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state       <= '0;
            state.entry <= ENTRY_INIT;
        end else begin
            state <= next_state;
        end
    end

    // =================================================================
    // Outputs
    // Every output comes straight from a flip-flop of the state
    assign reg_rdata                 = state.rdata;
    assign reg_ack                   = state.ack;
    assign dec_valid                 = state.valid;
    assign dec_hit                   = state.hit;
    assign dec_entry                 = state.idx;
    assign dec_permitted             = state.permitted;
    assign dec_priv_fault            = state.fault;
    assign privileged_only           = state.priv;
    assign first_source_read_enable  = state.src1;
    assign second_source_read_enable = state.src2;
    assign result_writeback_enable   = state.wback;
    assign condition_return_enable   = state.cr_en;
    assign condition_target_select   = state.cr_sel;
    assign dec_exec_type             = state.etype;
    assign entry_pointer             = state.ptr;

endmodule : cid_decode

// ### verif/cid_decode_properties.sv
`timescale 1ns/100ps
module cid_decode_props
    import cid_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        reg_en,
    input wire logic        reg_wr,
    input wire logic        reg_ack,
    input wire logic        instr_valid,
    input wire logic        priv_mode,
    input wire logic [9:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        dec_valid,
    input wire logic        dec_hit,
    input wire logic        dec_permitted,
    input wire logic        dec_priv_fault,
    input wire logic        privileged_only,
    input wire logic        condition_return_enable,
    input wire logic [3:0]  dec_entry,
    input wire logic [3:0]  entry_pointer,
    input wire logic [2:0]  condition_target_select,
    input wire cid_exec_t   dec_exec_type
);
    // ==========
    // Decode and register checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic take = reg_en && !reg_ack && reg_addr == 10'h004;
    wire logic ptr_ld = take && reg_wr && reg_wdata[5:4] == 2'b11;

    a_valid_follows: assert property (instr_valid |=> dec_valid)
        else $error("decode result missing");
    a_hit_valid: assert property (dec_hit |-> dec_valid)
        else $error("hit without valid");
    a_fault_cause: assert property (instr_valid |=> dec_priv_fault ==
        (dec_hit && privileged_only && !$past(priv_mode))) else $error("bad fault");
    a_permit_split: assert property (dec_hit |-> dec_permitted != dec_priv_fault)
        else $error("permit and fault clash");
    a_select_gated: assert property (!condition_return_enable |->
        condition_target_select == 3'h0) else $error("select leaks");
    a_miss_clears: assert property (!dec_hit |-> !privileged_only && dec_entry == 4'h0
        && dec_exec_type == CID_EARLY_CONFIRM) else $error("miss shows options");
    a_ptr_load: assert property (ptr_ld |=> entry_pointer == $past(reg_wdata[9:6]))
        else $error("pointer not loaded");
    a_ptr_hold: assert property (!ptr_ld |=> $stable(entry_pointer))
        else $error("pointer moved");
    a_ack_pulse: assert property (take |=> reg_ack ##1 !reg_ack)
        else $error("ack not one pulse");
    c_fault: cover property (dec_priv_fault);
    c_ptr: cover property (ptr_ld);
    c_cr_hit: cover property (dec_hit && condition_return_enable);
endmodule : cid_decode_props

bind cid_decode cid_decode_props i_props (.clk_sys, .rst, .reg_en, .reg_wr, .reg_ack,
    .instr_valid, .priv_mode, .reg_addr, .reg_wdata, .dec_valid, .dec_hit, .dec_permitted,
    .dec_priv_fault, .privileged_only, .condition_return_enable, .dec_entry, .entry_pointer,
    .condition_target_select, .dec_exec_type);

// ### verif/cid_pipe_model.sv
`timescale 1ns/100ps
module cid_pipe_model (
    input wire logic clk_sys,
    output logic     instr_valid,
    output logic [31:0] instr,
    output logic     priv_mode
);
    // ==========
    // Pipeline issue, one word per call
    initial begin
        instr_valid = 1'b0;
        instr = 32'h0000_0000;
        priv_mode = 1'b0;
    end
    // Idle word is inverted so a stale instruction can never match by accident
    task automatic issue(input logic [31:0] w, input logic p);
        @(negedge clk_sys);
        instr_valid = 1'b1;
        instr = w;
        priv_mode = p;
        @(negedge clk_sys);
        instr_valid = 1'b0;
        instr = ~w;
        priv_mode = ~p;
    endtask : issue
endmodule : cid_pipe_model

// ### verif/custom_instruction_decode_config_tb_top.sv
`timescale 1ns/100ps
module custom_instruction_decode_config_tb_top;
    import cid_pkg::*;
    localparam logic [15:0][31:0] INIT = {480'h0, 32'h9234_0001};
    logic clk_sys = 1'b0, rst = 1'b1, reg_en = 1'b0, reg_wr = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, instr, rd;
    logic reg_ack, instr_valid, priv_mode, dec_valid, dec_hit, dec_permitted, dec_priv_fault;
    logic privileged_only, first_source_read_enable, second_source_read_enable;
    logic result_writeback_enable, condition_return_enable;
    logic [3:0] dec_entry, entry_pointer;
    logic [2:0] condition_target_select;
    cid_exec_t dec_exec_type;
    int bad_count = 0, cmp_count = 0;
    wire logic [17:0] opts = {dec_valid, dec_hit, dec_entry, dec_permitted, dec_priv_fault,
        privileged_only, first_source_read_enable, second_source_read_enable,
        result_writeback_enable, condition_return_enable, condition_target_select, dec_exec_type};

    always #2 clk_sys = ~clk_sys;
    cid_decode #(.NUM_ENTRIES(16), .ENTRY_INIT(INIT)) i_dut (.clk_sys, .rst, .reg_en, .reg_wr,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .instr_valid, .instr, .priv_mode, .dec_valid,
        .dec_hit, .dec_entry, .dec_permitted, .dec_priv_fault, .privileged_only,
        .first_source_read_enable, .second_source_read_enable, .result_writeback_enable,
        .condition_return_enable, .condition_target_select, .dec_exec_type, .entry_pointer);
    cid_pipe_model i_pipe (.clk_sys, .instr_valid, .instr, .priv_mode);

    // ==========
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       output logic ack);
        ack = 1'b0;
        @(negedge clk_sys);
        reg_en = 1'b1;
        reg_wr = wr;
        reg_addr = a;
        reg_wdata = d;
        for (int i = 0; i < 4 && !ack; i++) begin
            @(negedge clk_sys);
            ack = (reg_ack === 1'b1);
        end
        rd = reg_rdata;
        // Hold the request through the edge that sees the ack, then let go
        if (ack) begin
            @(negedge clk_sys);
        end
        reg_en = 1'b0;
    endtask : bus
    task automatic dec(input logic [31:0] w, input logic p, input logic [17:0] exp);
        i_pipe.issue(w, p);
        chk({14'h0, opts}, {14'h0, exp});
    endtask : dec

    // ==========
    // Scenarios
    task automatic t_init_decode;
        logic ack;
        bus(1'b0, 10'h004, 32'h0000_0000, ack);
        chk(rd, 32'h9234_0001);
        dec(32'h1000_0123, 1'b0, 18'h3_0900);
    endtask : t_init_decode
    task automatic t_entry_options;
        logic ack;
        bus(1'b1, 10'h004, 32'h0000_0170, ack);
        chk({28'h0, entry_pointer}, 32'h0000_0005);
        bus(1'b0, 10'h004, 32'h0000_0000, ack);
        chk(rd, 32'h0000_0000);
        bus(1'b1, 10'h004, 32'h2AB9_A8D5, ack);
        bus(1'b0, 10'h004, 32'h0000_0000, ack);
        chk(rd, 32'h2AB9_A8D1);
        dec(32'h0000_02AB, 1'b0, 18'h3_5675);
        dec(32'h0000_02AB, 1'b1, 18'h3_5A75);
        bus(1'b0, 10'h005, 32'h0000_0000, ack);
        chk({31'h0, ack}, 32'h0000_0000);
    endtask : t_entry_options
    task automatic t_wildcard_enable;
        logic ack;
        bus(1'b1, 10'h004, 32'h0000_01B0, ack);
        bus(1'b1, 10'h004, 32'hFC52_1823, ack);
        dec(32'h1000_0005, 1'b0, 18'h3_6882);
        dec(32'h1000_0006, 1'b0, 18'h2_0000);
        dec(32'h0000_0005, 1'b0, 18'h2_0000);
        bus(1'b1, 10'h004, 32'hFC52_1822, ack);
        dec(32'h1000_0005, 1'b0, 18'h2_0000);
    endtask : t_wildcard_enable

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        t_init_decode();
        t_entry_options();
        t_wildcard_enable();
        tally_and_finish();
    end
    // About 43 cycles of traffic after 10 of reset; a long margin before declaring a hang
    initial begin
        repeat (1000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end
endmodule : custom_instruction_decode_config_tb_top
